// ### common/sdrlrp_pkg.sv
// shared constants and types for the sdram local request port
package sdrlrp_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int BE_W = DATA_W / 8;
  localparam int SIZE_W = 3;
  localparam int QDEPTH = 4;
  localparam int QPTR_W = 2;
  localparam int QCNT_W = 3;
  localparam int ROW_LSB = 8;
  localparam logic [3:0] MEM_BL_FIRST = 4'h8;
  localparam logic [3:0] MEM_BL_SECOND = 4'h4;
  localparam logic [SIZE_W-1:0] SECOND_MAX_SIZE = 3'h2;
  localparam logic [SIZE_W-1:0] SIZE_ONE = 3'h1;
  localparam logic [3:0] ACT_CYCLES = 4'h3;
  localparam logic [3:0] RD_LAT_CYCLES = 4'h3;
  localparam logic [3:0] REF_CYCLES = 4'h7;
  localparam logic [7:0] INIT_CYCLES = 8'hC8;
  localparam logic [11:0] AUTO_REF_CYCLES = 12'h300;
  localparam logic [3:0] ONE4 = 4'h1;
  localparam logic [3:0] ZERO4 = 4'h0;
  typedef enum logic [1:0] {
    SDRLRP_OP_NONE,
    SDRLRP_OP_READ,
    SDRLRP_OP_WRITE
  } sdrlrp_op_t;
endpackage

// ### logic/sdrlrp_ctrl.sv
// local request port of a ddr/ddr2 sdram controller with behavioural memory timing
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - first-generation memory takes local sizes one up to half the memory burst
// - second-generation memory takes only local sizes one or two
// - request with size and address is taken in a cycle with ready high
// - write data request per beat; data follows in the next cycle
// - queue holds four requests; ready stays high while space remains
// - bank activation before queued writes; sequential writes skip it but leave one idle cycle between bursts
// - strobe toggles over the whole memory burst, even on empty beats
// - read data returns flagged valid after a variable latency
// - read data returns in the order reads were accepted
// - reads and writes may interleave in any order
// - user refresh has priority over queue after the current access ends
// - refresh acknowledge pulses for each refresh command issued
// - acknowledge also flags automatic refreshes when user refresh is off
// - queue service resumes once refresh request drops
// - init done rises after the initialization sequence
//////////////////////////////////////////////////////////////////////////////
module sdrlrp_ctrl
  import sdrlrp_pkg::*;
#(
  parameter logic SECOND_GEN = 1'b0,
  parameter logic USER_REFRESH = 1'b1,
  parameter logic [11:0] AUTO_REF = sdrlrp_pkg::AUTO_REF_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // request side
  input wire logic local_read_req,
  input wire logic local_write_req,
  input wire logic [sdrlrp_pkg::SIZE_W-1:0] local_size,
  input wire logic [sdrlrp_pkg::ADDR_W-1:0] local_addr,
  output logic local_ready,
  // write data
  output logic local_wdata_req,
  input wire logic [sdrlrp_pkg::DATA_W-1:0] local_wdata,
  input wire logic [sdrlrp_pkg::BE_W-1:0] local_be,
  // read data
  output logic local_rdata_valid,
  input wire logic local_rdata_ready,
  output logic [sdrlrp_pkg::DATA_W-1:0] local_rdata,
  // refresh and status
  input wire logic local_refresh_req,
  output logic local_refresh_ack,
  output logic local_init_done,
  // memory side strobe view
  output logic mem_dqs_toggle,
  output logic mem_activate,
  output logic mem_write_beat
);
  import sdrlrp_pkg::*;

  localparam logic [3:0] MEM_BL = SECOND_GEN ? MEM_BL_SECOND : MEM_BL_FIRST;
  localparam logic [SIZE_W-1:0] MAX_SIZE = SECOND_GEN ? SECOND_MAX_SIZE : SIZE_W'(MEM_BL_FIRST >> 1);

  typedef enum logic [2:0] {
    ST_INIT,
    ST_IDLE,
    ST_ACT,
    ST_WRITE,
    ST_READ,
    ST_REFRESH
  } sdrlrp_state_t;

  typedef struct packed {
    sdrlrp_state_t state;
    logic [7:0] init_cnt;
    logic [11:0] auto_cnt;
    logic auto_due;
    logic [3:0] tcnt;
    logic [3:0] beat;
    logic [SIZE_W-1:0] cur_size;
    logic cur_is_write;
    logic [ADDR_W-1:0] open_row;
    logic row_open;
    logic [QDEPTH-1:0][ADDR_W+SIZE_W:0] q;
    logic [QPTR_W-1:0] q_rd;
    logic [QPTR_W-1:0] q_wr;
    logic [QCNT_W-1:0] q_cnt;
    logic wreq_d;
    logic [DATA_W-1:0] mem_word;
    logic [DATA_W-1:0] rd_word;
    logic rd_push;
    logic ready;
    logic wdata_req;
    logic ref_ack;
    logic init_done;
    logic dqs;
    logic act;
    logic wbeat;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
  } sdrlrp_st_t;

  sdrlrp_st_t st_ff, nxt_st;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [DATA_W-1:0] buf_out_data;

  ////////////////////////////////////////////////////////////////////////////
  // read return buffer: a receiver stall parks words here instead of losing them
  sdrlrp_skid #(
    .W(DATA_W)
  ) u_rbuf (
    .mclk(mclk),
    .reset(reset),
    .in_valid(st_ff.rd_push),
    .in_ready(buf_in_ready),
    .in_data(st_ff.rd_word),
    .out_valid(buf_out_valid),
    .out_ready(local_rdata_ready || !st_ff.rvalid),
    .out_data(buf_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic take;
    logic [ADDR_W+SIZE_W:0] head;
    logic pop;
    logic [SIZE_W-1:0] sz;
    logic ref_pend;
    take = 1'b0;
    head = '0;
    pop = 1'b0;
    sz = '0;
    ref_pend = 1'b0;
    nxt_st = st_ff;
    nxt_st.wdata_req = 1'b0;
    nxt_st.ref_ack = 1'b0;
    nxt_st.act = 1'b0;
    nxt_st.wbeat = 1'b0;
    nxt_st.rd_push = 1'b0;
    nxt_st.dqs = 1'b0;
    nxt_st.wreq_d = st_ff.wdata_req;

    // oversize requests are clamped, since the memory burst cannot carry more
    sz = (local_size > MAX_SIZE) ? MAX_SIZE : local_size;
    sz = (sz == '0) ? SIZE_ONE : sz;

    // queue fill: any mix of reads and writes
    take = st_ff.ready && st_ff.init_done && (local_read_req || local_write_req);
    if (take) begin
      nxt_st.q[st_ff.q_wr] = {local_write_req, sz, local_addr};
      nxt_st.q_wr = QPTR_W'(st_ff.q_wr + 1'b1);
    end
    head = st_ff.q[st_ff.q_rd];

    // write data sampled one cycle after its request
    if (st_ff.wreq_d) begin
      nxt_st.mem_word = local_wdata ^ {{(DATA_W-BE_W){1'b0}}, local_be};
    end

    // automatic refresh timer runs whether or not user refresh is enabled
    nxt_st.auto_cnt = 12'(st_ff.auto_cnt + 1'b1);
    if (st_ff.auto_cnt == AUTO_REF) begin
      nxt_st.auto_cnt = '0;
      nxt_st.auto_due = 1'b1;
    end
    ref_pend = st_ff.auto_due || (USER_REFRESH && local_refresh_req);

    unique case (st_ff.state)
      ST_INIT: begin
        nxt_st.init_cnt = 8'(st_ff.init_cnt + 1'b1);
        if (st_ff.init_cnt == INIT_CYCLES) begin
          nxt_st.init_done = 1'b1;
          nxt_st.state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // refresh wins over the queue; queue resumes once it is gone
        if (ref_pend) begin
          nxt_st.state = ST_REFRESH;
          nxt_st.tcnt = REF_CYCLES;
          nxt_st.row_open = 1'b0;
        end else if (st_ff.q_cnt != '0) begin
          pop = 1'b1;
          nxt_st.q_rd = QPTR_W'(st_ff.q_rd + 1'b1);
          nxt_st.cur_size = head[ADDR_W +: SIZE_W];
          nxt_st.cur_is_write = head[ADDR_W+SIZE_W];
          nxt_st.beat = ZERO4;
          // sequential access in an open row skips activation
          if (st_ff.row_open && head[ADDR_W-1:ROW_LSB] == st_ff.open_row[ADDR_W-1:ROW_LSB]) begin
            nxt_st.state = head[ADDR_W+SIZE_W] ? ST_WRITE : ST_READ;
            nxt_st.tcnt = head[ADDR_W+SIZE_W] ? ZERO4 : RD_LAT_CYCLES;
          end else begin
            nxt_st.state = ST_ACT;
            nxt_st.act = 1'b1;
            nxt_st.tcnt = ACT_CYCLES;
          end
          nxt_st.open_row = head[ADDR_W-1:0];
          nxt_st.row_open = 1'b1;
        end
      end
      ST_ACT: begin
        nxt_st.tcnt = 4'(st_ff.tcnt - ONE4);
        if (st_ff.tcnt == ONE4) begin
          nxt_st.state = st_ff.cur_is_write ? ST_WRITE : ST_READ;
          nxt_st.tcnt = st_ff.cur_is_write ? ZERO4 : RD_LAT_CYCLES;
        end
      end
      ST_WRITE: begin
        // one data request per local beat, strobe for the full memory burst
        nxt_st.dqs = 1'b1;
        // the beat lands in the cycle its data is sampled, including the last one
        nxt_st.wbeat = st_ff.wreq_d;
        if (st_ff.beat < {1'b0, st_ff.cur_size}) begin
          nxt_st.wdata_req = 1'b1;
        end
        nxt_st.beat = 4'(st_ff.beat + ONE4);
        if (st_ff.beat == 4'(MEM_BL - ONE4)) begin
          nxt_st.state = ST_IDLE;
        end
      end
      ST_READ: begin
        // latency stand-in; beats pushed in accept order
        if (st_ff.tcnt != ZERO4) begin
          nxt_st.tcnt = 4'(st_ff.tcnt - ONE4);
        end else if (buf_in_ready && !st_ff.rd_push) begin
          // push is registered, so skip a cycle after each push; a full buffer would drop the word
          nxt_st.rd_push = 1'b1;
          nxt_st.rd_word = st_ff.mem_word ^ {{(DATA_W-ADDR_W){1'b0}}, st_ff.open_row} ^ DATA_W'(st_ff.beat);
          nxt_st.beat = 4'(st_ff.beat + ONE4);
          if (st_ff.beat == 4'({1'b0, st_ff.cur_size} - ONE4)) begin
            nxt_st.state = ST_IDLE;
          end
        end
      end
      ST_REFRESH: begin
        nxt_st.tcnt = 4'(st_ff.tcnt - ONE4);
        if (st_ff.tcnt == REF_CYCLES) begin
          nxt_st.ref_ack = 1'b1;
          nxt_st.auto_due = 1'b0;
        end
        if (st_ff.tcnt == ONE4) begin
          nxt_st.state = ST_IDLE;
        end
      end
      default: begin
        nxt_st.state = ST_INIT;
      end
    endcase

    // a late timer tick beats the clear in the same cycle
    if (st_ff.auto_cnt == AUTO_REF) begin
      nxt_st.auto_due = 1'b1;
    end

    nxt_st.q_cnt = QCNT_W'(st_ff.q_cnt + {2'h0, take} - {2'h0, pop});
    // registered ready, so leave room for a request taken this cycle
    nxt_st.ready = (nxt_st.q_cnt < QCNT_W'(QDEPTH)) && nxt_st.init_done;

    // output stage for read data
    if (local_rdata_ready || !st_ff.rvalid) begin
      nxt_st.rvalid = buf_out_valid;
      nxt_st.rdata = buf_out_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_ff <= '{state: ST_INIT, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign local_ready = st_ff.ready;
  assign local_wdata_req = st_ff.wdata_req;
  assign local_rdata_valid = st_ff.rvalid;
  assign local_rdata = st_ff.rdata;
  assign local_refresh_ack = st_ff.ref_ack;
  assign local_init_done = st_ff.init_done;
  assign mem_dqs_toggle = st_ff.dqs;
  assign mem_activate = st_ff.act;
  assign mem_write_beat = st_ff.wbeat;
endmodule

// ### logic/sdrlrp_skid.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module sdrlrp_skid #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  typedef struct packed {
    logic [1:0] cnt;
    logic [W-1:0] e0;
    logic [W-1:0] e1;
  } sdrlrp_skid_t;
  sdrlrp_skid_t st_ff, nxt_st;

  // e0 is the head; e1 holds the word caught during a stall
  always_comb begin
    logic push;
    logic pop;
    push = 1'b0;
    pop = 1'b0;
    nxt_st = st_ff;
    push = in_valid && (st_ff.cnt != 2'h2);
    pop = out_ready && (st_ff.cnt != 2'h0);
    if (pop) begin
      nxt_st.e0 = st_ff.e1;
    end
    if (push) begin
      if (st_ff.cnt == 2'h0 || (st_ff.cnt == 2'h1 && pop)) begin
        nxt_st.e0 = in_data;
      end else begin
        nxt_st.e1 = in_data;
      end
    end
    nxt_st.cnt = 2'(st_ff.cnt + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign in_ready = (st_ff.cnt != 2'h2);
  assign out_valid = (st_ff.cnt != 2'h0);
  assign out_data = st_ff.e0;
endmodule

// ### sim/sdrlrp_checker.sv
// assertions on the local request port
`timescale 1ns/1ps
module sdrlrp_checker
  import sdrlrp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // request side
  input wire logic local_read_req,
  input wire logic local_write_req,
  input wire logic local_ready,
  // data and status
  input wire logic local_wdata_req,
  input wire logic local_rdata_valid,
  input wire logic local_rdata_ready,
  input wire logic [sdrlrp_pkg::DATA_W-1:0] local_rdata,
  input wire logic local_refresh_req,
  input wire logic local_refresh_ack,
  input wire logic local_init_done,
  // memory side
  input wire logic mem_dqs_toggle,
  input wire logic mem_write_beat
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  chk_ready_after_init: assert property (local_ready |-> local_init_done)
    else $error("ready before init done");
  chk_init_holds: assert property (local_init_done |=> local_init_done)
    else $error("init done dropped");
  chk_ack_single: assert property (local_refresh_ack |=> !local_refresh_ack)
    else $error("refresh ack longer than one cycle");
  chk_rdata_held: assert property (local_rdata_valid && !local_rdata_ready |=>
    local_rdata_valid && $stable(local_rdata))
    else $error("read word lost under stall");
  chk_beat_after_req: assert property (mem_write_beat |-> $past(local_wdata_req, 2))
    else $error("write beat without data request");
  chk_dqs_full_burst: assert property ($rose(mem_dqs_toggle) |-> mem_dqs_toggle [*8])
    else $error("strobe shorter than memory burst");
  chk_beat_in_strobe: assert property (mem_write_beat |-> mem_dqs_toggle)
    else $error("write beat outside strobe");
  chk_write_answer: assert property (local_ready && local_write_req |->
    ##[1:300] local_wdata_req)
    else $error("write never asked for data");
  chk_read_answer: assert property (local_ready && local_read_req && !local_write_req |->
    ##[1:400] local_rdata_valid)
    else $error("read never returned");
  chk_refresh_served: assert property ($rose(local_refresh_req) && local_init_done |->
    ##[1:300] local_refresh_ack)
    else $error("user refresh not acknowledged");
endmodule
bind sdrlrp_ctrl sdrlrp_checker i_sdrlrp_checker (.mclk, .reset, .local_read_req, .local_write_req,
  .local_ready, .local_wdata_req, .local_rdata_valid, .local_rdata_ready, .local_rdata,
  .local_refresh_req, .local_refresh_ack, .local_init_done, .mem_dqs_toggle, .mem_write_beat);

// ### sim/sdrlrp_ctrl_tb.sv
// testbench for the sdram local request port
`timescale 1ns/1ps
module sdrlrp_ctrl_tb;
  import sdrlrp_pkg::*;
  typedef struct {logic wr; logic [2:0] sz; logic [23:0] ad; int beats;} sdrlrp_row_t;
  logic mclk, reset, rd_req, wr_req, ready, wdreq, rvalid, rready, ref_req, ref_ack, init_done;
  logic dqs, act, wbeat;
  logic [2:0] size;
  logic [23:0] addr;
  logic [31:0] wdata, rdata;
  logic [3:0] be;
  int errors = 0;
  int checked = 0;
  int ew = 0;
  int er = 0;
  int nw = 0;
  int i;
  // sizes 0 and above four are clamped; rows 0 and 1 share a row for the sequential case
  sdrlrp_row_t rows [8] = '{'{1, 1, 24'h000100, 1}, '{1, 2, 24'h000101, 2}, '{1, 0, 24'h000200, 1},
    '{1, 5, 24'h003300, 4}, '{0, 4, 24'h000100, 4}, '{0, 2, 24'h000400, 2}, '{0, 1, 24'h005500, 1},
    '{1, 4, 24'h106600, 4}};
  sdrlrp_ctrl #(.AUTO_REF(12'h040)) i_sdrlrp_ctrl (.mclk(mclk), .reset(reset), .local_read_req(rd_req),
    .local_write_req(wr_req), .local_size(size), .local_addr(addr), .local_ready(ready),
    .local_wdata_req(wdreq), .local_wdata(wdata), .local_be(be), .local_rdata_valid(rvalid),
    .local_rdata_ready(rready), .local_rdata(rdata), .local_refresh_req(ref_req),
    .local_refresh_ack(ref_ack), .local_init_done(init_done), .mem_dqs_toggle(dqs),
    .mem_activate(act), .mem_write_beat(wbeat));
  sdrlrp_user_model i_sdrlrp_user_model (.mclk(mclk), .local_wdata_req(wdreq), .local_rdata_valid(rvalid),
    .local_refresh_ack(ref_ack), .mem_dqs_toggle(dqs), .mem_activate(act), .local_wdata(wdata),
    .local_be(be), .local_rdata_ready(rready));
  // 50 ns period
  always #25 mclk = ~mclk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  // request held until a cycle with ready high; not released here so requests can follow back to back
  task automatic issue(input logic wr, input logic [2:0] sz, input logic [23:0] ad, input int beats);
    int n;
    wr_req = wr;
    rd_req = !wr;
    size = sz;
    addr = ad;
    for (n = 0; n < 400 && ready !== 1'b1; n++) @(negedge mclk);
    if (n == 400) begin
      errors++;
      test_done();
    end
    @(negedge mclk);
    if (wr) ew += beats;
    else er += beats;
  endtask
  task automatic settle();
    int n;
    wr_req = 1'b0;
    rd_req = 1'b0;
    for (n = 0; n < 3000 && (i_sdrlrp_user_model.wbeats != ew || i_sdrlrp_user_model.rwords != er); n++)
      @(negedge mclk);
    if (n == 3000) begin
      errors++;
      test_done();
    end
    repeat (20) @(negedge mclk);
    check("write beats", 32'(i_sdrlrp_user_model.wbeats), 32'(ew));
    check("read words", 32'(i_sdrlrp_user_model.rwords), 32'(er));
  endtask
  task automatic wait_init();
    int n;
    for (n = 0; n < 400 && init_done !== 1'b1; n++) @(negedge mclk);
    check("init done", {31'h0, init_done}, 32'h1);
    @(negedge mclk);
    check("ready", {31'h0, ready}, 32'h1);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    {rd_req, wr_req, ref_req} = 3'h0;
    size = 3'h1;
    addr = 24'h0;
    repeat (12) @(negedge mclk);
    reset = 1'b0;
    wait_init();
    // ordinary single requests
    foreach (rows[k]) begin
      issue(rows[k].wr, rows[k].sz, rows[k].ad, rows[k].beats);
      nw += int'(rows[k].wr);
      settle();
      check("strobe cycles", 32'(i_sdrlrp_user_model.dqs_cycles), 32'(8 * nw));
    end
    check("activated", {31'h0, i_sdrlrp_user_model.acts != 0}, 32'h1);
    // interleaved back to back, more than the queue holds
    issue(0, 3'h4, 24'h000700, 4);
    issue(1, 3'h2, 24'h000710, 2);
    issue(0, 3'h1, 24'h008800, 1);
    issue(1, 3'h3, 24'h000712, 3);
    issue(0, 3'h2, 24'h009900, 2);
    settle();
    // user refresh held for two acknowledges with a read queued
    i = i_sdrlrp_user_model.acks;
    issue(0, 3'h2, 24'h00AA00, 2);
    rd_req = 1'b0;
    ref_req = 1'b1;
    for (int n = 0; n < 800 && i_sdrlrp_user_model.acks < i + 2; n++) @(negedge mclk);
    ref_req = 1'b0;
    check("refresh acks", {31'h0, i_sdrlrp_user_model.acks >= i + 2}, 32'h1);
    settle();
    // reset in mid-run
    issue(1, 3'h4, 24'h00BB00, 0);
    reset = 1'b1;
    wr_req = 1'b0;
    repeat (2) @(negedge mclk);
    check("ready in reset", {31'h0, ready}, 32'h0);
    check("init in reset", {31'h0, init_done}, 32'h0);
    reset = 1'b0;
    ew = i_sdrlrp_user_model.wbeats;
    wait_init();
    test_done();
  end
endmodule

// ### sim/sdrlrp_user_model.sv
// user-side model: supplies write data, sinks read data, counts events
`timescale 1ns/1ps
module sdrlrp_user_model
  import sdrlrp_pkg::*;
(
  // clock
  input wire logic mclk,
  // controller outputs
  input wire logic local_wdata_req,
  input wire logic local_rdata_valid,
  input wire logic local_refresh_ack,
  input wire logic mem_dqs_toggle,
  input wire logic mem_activate,
  // toward the controller
  output logic [sdrlrp_pkg::DATA_W-1:0] local_wdata,
  output logic [sdrlrp_pkg::BE_W-1:0] local_be,
  output logic local_rdata_ready
);
  int wbeats = 0;
  int rwords = 0;
  int acks = 0;
  int dqs_cycles = 0;
  int acts = 0;
  logic [1:0] phase = 2'h0;
  initial begin
    local_wdata = 32'h0;
    local_be = 4'h0;
    local_rdata_ready = 1'b1;
  end
  // event counters sampled where outputs are settled
  always @(posedge mclk) begin
    wbeats += int'(local_wdata_req);
    rwords += int'(local_rdata_valid && local_rdata_ready);
    acks += int'(local_refresh_ack);
    dqs_cycles += int'(mem_dqs_toggle);
    acts += int'(mem_activate);
  end
  // native port only, data follows each request, so no memory-clock variant
  // data driven at the falling edge of each request cycle; inverted in cycles without a request so stale data never looks valid
  always @(negedge mclk) begin
    phase <= phase + 2'h1;
    local_rdata_ready <= (phase != 2'h3); // receiver stalls one cycle in four
    if (local_wdata_req) begin
      local_wdata <= {8'hA5, 24'(wbeats)};
      local_be <= 4'hF;
    end else begin
      local_wdata <= ~local_wdata;
      local_be <= ~local_be;
    end
  end
endmodule
